// ==== src/bus_cycle_regs.vh ====
// constants for the backplane bus cycle controller
// assumes a 50 MHz reference clock and a host that includes this header once per unit
`ifndef BUS_CYCLE_REGS_VH
`define BUS_CYCLE_REGS_VH
// register offsets (byte addresses, one word each)
`define REG_CTRL        4'h0
`define REG_ADDR        4'h4
`define REG_WDATA       4'h8
`define REG_STATUS      4'hC
// control register fields
`define CTRL_GO_BIT     0
`define CTRL_IAK_BIT    1
`define CTRL_WRITE_BIT  2
`define CTRL_BYTE_BIT   3
`define CTRL_RMW_BIT    4
`define CTRL_CON_BIT    5
`define CTRL_IOP_BIT    6
`define CTRL_RESET      7'h00
// status register fields
`define STAT_BUSY_BIT   0
`define STAT_PERR_BIT   1
`define STAT_LACK_BIT   2
// one oscillator period (150 ns) in whole reference clock cycles, rounded up
`define OSC_PERIOD_NS   8'h96
`define OSC_CYCLES      8'h08
`define HALF_CYCLES     8'h04
// parity trap vector, octal 114
`define PAR_TRAP_VEC    16'h004C
`endif

// ==== src/bus_cycle_ctrl.v ====
// backplane bus cycle controller: read, interrupt-acknowledge read and write cycles
// assumes synchronous backplane inputs and a classic wishbone master for control
// Functional notes
// - sync asserts half period before phase one ends, not on acknowledge reads
// - data-in strobe asserts half period into phase three on reads
// - address drive drops at end of phase three on reads
// - one period into phase four, onboard or backplane data routes to processor bus
// - ordinary read holds in phase four until reply, internal read, or mapper
// - end of phase five clocks processor bus data into the chip set
// - acknowledge microbit stays negated on ordinary reads
// - local ack enable set at phase one if serial unit requests, no level 5/6
// - local ack: internal read one period into phase four, serial vector
// - otherwise backplane read; ack out sets two periods into phase four, gate stage3 clear
// - acknowledge read holds in phase four until reply, internal read, or mapper
// - write data loads backplane registers at end of phase three, also onboard
// - internal write strobe on end of phase two, off one period into phase five
// - read-modify-write holds write in phase four until reply stage3 negates
// - data-out strobe sets one period into phase five
// - write holds in phase five until mapper, backplane reply, or internal select with strobe off
// - output stage two delays data drive release by one period each edge
// - read enable passes backplane bits 18..0 onto processor bus
// - end of phase-bar decodes microbits 7:6 into console cycle flag
// - io page select on normal cycles; forced off on console if bit 17/16 clear
// - byte flag set in address part, byte/word in data part, not on reads
// - reads capture bits 17:16; both set gives parity error, reset, trap 114
// - sync held until bus hold clears and slave releases reply
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "bus_cycle_regs.vh"
module bus_cycle_ctrl (
    input  wire        ref_clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output wire        wb_ack_o,
    // backplane side
    input  wire [18:0] bdal_i,
    output reg  [18:0] bdal_o,
    output wire        bdal_oe_o,
    output reg         bsync_o,
    output reg         bdin_o,
    output reg         bdout_o,
    output reg         biako_o,
    output reg         bbs7_o,
    output reg         bwtbt_o,
    input  wire        brply_i,
    input  wire        birq5_i,
    input  wire        birq6_i,
    // on-board side
    input  wire        serial_unit_int_request_i,
    input  wire        mapper_reply_i,
    input  wire        internal_address_select_i,
    input  wire        console_addr_bit17_i,
    input  wire        console_addr_bit16_i,
    input  wire [1:0]  microbits_7_6_i,
    input  wire [15:0] onboard_register_bus_i,
    output reg  [15:0] onboard_register_bus_o,
    output reg         internal_write_strobe_o,
    output reg         interrupt_ack_microbit_o,
    output reg  [18:0] processor_bus_o,
    output reg  [15:0] chip_set_data_o,
    output reg         chip_set_load_o,
    output reg         chip_reset_o,
    output reg  [15:0] trap_vector_o
);

    // phase time states
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_PBT  = 4'h1;
    localparam [3:0] ST_PT1  = 4'h2;
    localparam [3:0] ST_PT2  = 4'h3;
    localparam [3:0] ST_PT3  = 4'h4;
    localparam [3:0] ST_PT4  = 4'h5;
    localparam [3:0] ST_PT5  = 4'h6;
    localparam [3:0] ST_END  = 4'h7;

    localparam [7:0] OSC_N  = `OSC_CYCLES;
    localparam [7:0] HALF_N = `HALF_CYCLES;

    // registers visible to software
    reg  [6:0]  ctrl_q;
    reg  [18:0] addr_q;
    reg  [15:0] wdata_q;
    reg         ack_q;

    // sequencer state
    reg  [3:0]  state_q;
    reg  [7:0]  tick_q;        // reference cycles into the current phase
    reg         is_write_q;
    reg         is_iak_q;
    reg         is_rmw_q;
    reg         is_byte_q;
    reg         io_page_q;
    reg         console_cycle_ff_q;
    reg         sync_enable_flag_q;
    reg         local_ack_enable_q;
    reg         backplane_drive_gate_q;
    reg         gate_stage3_q;
    reg         gate_stage3_dly_q;
    reg         backplane_read_enable_q;
    reg         internal_bus_read_q;
    reg         output_strobe_stage2_q;
    reg  [`OSC_CYCLES-2:0] strobe_pipe_q;  // data-out strobe delay line
    reg         reply_sync_stage3_q;
    reg         bus_hold_state_q;
    reg  [1:0]  captured_parity_bits_q;
    reg         address_parity_error_q;

    wire bus_hit   = wb_cyc_i & wb_stb_i & ~ack_q;
    wire busy      = (state_q != ST_IDLE);
    wire one_osc   = (tick_q >= OSC_N - 8'h01);
    wire half_osc  = (tick_q == HALF_N);

    // decode of a register word offset, used by read and write paths
    function is_reg;
        input [3:0] adr;
        input [3:0] off;
        begin
            is_reg = (adr[3:2] == off[3:2]);
        end
    endfunction

    // single-cycle wishbone answer; writes take effect on the ack edge
    assign wb_ack_o  = ack_q;
    assign bdal_oe_o = backplane_drive_gate_q | output_strobe_stage2_q;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_q <= bus_hit;
            if (bus_hit & ~wb_we_i) begin
                if (is_reg(wb_adr_i, `REG_CTRL))
                    wb_dat_o <= {25'h000_0000, ctrl_q};
                else if (is_reg(wb_adr_i, `REG_ADDR))
                    wb_dat_o <= {13'h0000, addr_q};
                else if (is_reg(wb_adr_i, `REG_WDATA))
                    wb_dat_o <= {16'h0000, wdata_q};
                else
                    wb_dat_o <= {13'h0000, processor_bus_o[15:0],
                                 local_ack_enable_q, address_parity_error_q, busy};
            end
        end
    end

    // software registers; the go bit self-clears when the cycle starts
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_q  <= `CTRL_RESET;
            addr_q  <= 19'h00000;
            wdata_q <= 16'h0000;
        end else begin
            if (bus_hit & wb_we_i & wb_sel_i[0] & is_reg(wb_adr_i, `REG_CTRL))
                ctrl_q <= wb_dat_i[6:0];
            else if (state_q == ST_PBT)
                ctrl_q[`CTRL_GO_BIT] <= 1'b0;
            if (bus_hit & wb_we_i & is_reg(wb_adr_i, `REG_ADDR))
                addr_q <= wb_dat_i[18:0];
            if (bus_hit & wb_we_i & is_reg(wb_adr_i, `REG_WDATA))
                wdata_q <= wb_dat_i[15:0];
        end
    end

    // phase sequencer with pauses
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            tick_q  <= 8'h00;
        end else begin
            tick_q <= tick_q + 8'h01;
            case (state_q)
                ST_IDLE: begin
                    tick_q <= 8'h00;
                    if (ctrl_q[`CTRL_GO_BIT] & ~bus_hold_state_q & ~brply_i)
                        state_q <= ST_PBT;
                end
                ST_PBT, ST_PT1, ST_PT2: if (one_osc) begin
                    state_q <= state_q + 4'h1;
                    tick_q  <= 8'h00;
                end
                ST_PT3: if (one_osc & (~sync_enable_flag_q | gate_stage3_q)) begin
                    state_q <= ST_PT4;
                    tick_q  <= 8'h00;
                end
                ST_PT4: begin
                    if (tick_q >= OSC_N + OSC_N) begin
                        tick_q <= tick_q;
                        if (is_write_q ? (~is_rmw_q | ~reply_sync_stage3_q) :
                            (brply_i | mapper_reply_i |
                             internal_bus_read_q)) begin
                            state_q <= ST_PT5;
                            tick_q  <= 8'h00;
                        end
                    end
                end
                ST_PT5: begin
                    if (tick_q >= OSC_N) begin
                        tick_q <= tick_q;
                        if (~is_write_q | mapper_reply_i | brply_i |
                            (internal_address_select_i & ~internal_write_strobe_o)) begin
                            state_q <= ST_END;
                            tick_q  <= 8'h00;
                        end
                    end
                end
                ST_END: if (~output_strobe_stage2_q & ~|strobe_pipe_q & ~bdout_o)
                    state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // cycle qualifiers, address capture, backplane gating
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            is_write_q <= 1'b0;
            is_iak_q <= 1'b0;
            is_rmw_q <= 1'b0;
            is_byte_q <= 1'b0;
            io_page_q <= 1'b0;
            console_cycle_ff_q <= 1'b0;
            sync_enable_flag_q <= 1'b0;
            local_ack_enable_q <= 1'b0;
            backplane_drive_gate_q <= 1'b0;
            gate_stage3_q <= 1'b0;
            gate_stage3_dly_q <= 1'b0;
            bdal_o <= 19'h00000;
            bbs7_o <= 1'b0;
            bwtbt_o <= 1'b0;
            interrupt_ack_microbit_o <= 1'b0;
            bus_hold_state_q <= 1'b0;
        end else begin
            gate_stage3_dly_q <= gate_stage3_q;
            if (state_q == ST_IDLE && ctrl_q[`CTRL_GO_BIT]) begin
                is_write_q <= ctrl_q[`CTRL_WRITE_BIT];
                is_iak_q   <= ctrl_q[`CTRL_IAK_BIT] & ~ctrl_q[`CTRL_WRITE_BIT];
                is_rmw_q   <= ctrl_q[`CTRL_RMW_BIT];
                is_byte_q  <= ctrl_q[`CTRL_BYTE_BIT];
                io_page_q  <= ctrl_q[`CTRL_IOP_BIT];
                sync_enable_flag_q <= ~(ctrl_q[`CTRL_IAK_BIT] & ~ctrl_q[`CTRL_WRITE_BIT]);
            end
            if (state_q == ST_PBT && one_osc)
                console_cycle_ff_q <= (microbits_7_6_i == 2'h1);
            interrupt_ack_microbit_o <= busy & is_iak_q;
            if (state_q == ST_PT1 && tick_q == 8'h00)
                local_ack_enable_q <= is_iak_q & serial_unit_int_request_i
                                      & ~birq5_i & ~birq6_i;
            else if (state_q == ST_IDLE && ctrl_q[`CTRL_GO_BIT])
                local_ack_enable_q <= 1'b0; // kept until next start for status
            // address loads at end of phase two, data at end of phase three in write
            if (state_q == ST_PT2 && one_osc) begin
                bdal_o <= addr_q;
                bbs7_o <= io_page_q & ~(console_cycle_ff_q &
                          ~(console_addr_bit17_i & console_addr_bit16_i));
                bwtbt_o <= is_write_q;
                if (sync_enable_flag_q)
                    backplane_drive_gate_q <= 1'b1;
            end
            if (state_q == ST_PT3 && one_osc) begin
                if (is_write_q) begin
                    bdal_o  <= {3'h0, wdata_q};
                    bwtbt_o <= is_byte_q;
                end else begin
                    backplane_drive_gate_q <= 1'b0;
                    bwtbt_o <= 1'b0;
                end
            end
            // gate stage3 sets on the first phase-three clock once address is driven
            if (backplane_drive_gate_q & ~is_write_q & state_q == ST_PT3)
                gate_stage3_q <= 1'b1;
            else if (~backplane_drive_gate_q)
                gate_stage3_q <= 1'b0;
            else if (state_q == ST_PT3)
                gate_stage3_q <= 1'b1;
            // write data drive released only after stage two clears
            if (state_q == ST_END && ~output_strobe_stage2_q && ~|strobe_pipe_q && ~bdout_o)
                backplane_drive_gate_q <= 1'b0;
            bus_hold_state_q <= busy;
        end
    end

    // strobes, sync, acknowledge, reads, writes
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            bsync_o <= 1'b0;
            bdin_o <= 1'b0;
            bdout_o <= 1'b0;
            biako_o <= 1'b0;
            output_strobe_stage2_q <= 1'b0;
            strobe_pipe_q <= {(`OSC_CYCLES-1){1'b0}};
            internal_write_strobe_o <= 1'b0;
            backplane_read_enable_q <= 1'b0;
            internal_bus_read_q <= 1'b0;
            reply_sync_stage3_q <= 1'b0;
            onboard_register_bus_o <= 16'h0000;
            processor_bus_o <= 19'h00000;
        end else begin
            reply_sync_stage3_q <= brply_i;
            if (state_q == ST_PT1 && tick_q == OSC_N - HALF_N && sync_enable_flag_q)
                bsync_o <= 1'b1;
            else if (~bus_hold_state_q & ~busy & ~brply_i)
                bsync_o <= 1'b0;
            if (state_q == ST_PT3 && half_osc && ~is_write_q)
                bdin_o <= 1'b1;
            else if (state_q == ST_END || state_q == ST_IDLE)
                bdin_o <= 1'b0;
            if (state_q == ST_PT4 && tick_q == OSC_N && ~is_write_q) begin
                if (is_iak_q & local_ack_enable_q)
                    internal_bus_read_q <= 1'b1;
                else if (~is_iak_q & internal_address_select_i)
                    internal_bus_read_q <= 1'b1;
                else
                    backplane_read_enable_q <= 1'b1;
            end else if (state_q == ST_PT5) begin
                internal_bus_read_q <= 1'b0;
                backplane_read_enable_q <= 1'b0;
            end
            if (is_iak_q & ~local_ack_enable_q & ~gate_stage3_q &
                gate_stage3_dly_q == 1'b0 & state_q == ST_PT4 & tick_q == OSC_N + OSC_N)
                biako_o <= 1'b1;
            else if (state_q == ST_IDLE)
                biako_o <= 1'b0;
            if (internal_bus_read_q)
                processor_bus_o <= {3'h0, onboard_register_bus_i};
            else if (backplane_read_enable_q)
                processor_bus_o <= bdal_i;
            if (state_q == ST_PT2 && one_osc && is_write_q)
                internal_write_strobe_o <= 1'b1;
            else if (state_q == ST_PT5 && tick_q == OSC_N)
                internal_write_strobe_o <= 1'b0;
            if (state_q == ST_PT3 && one_osc && is_write_q)
                onboard_register_bus_o <= wdata_q;
            if (state_q == ST_PT5 && tick_q == OSC_N && is_write_q)
                bdout_o <= 1'b1;
            else if (state_q == ST_END)
                bdout_o <= 1'b0;
            // stage two trails the strobe by one oscillator period on both edges
            strobe_pipe_q <= {strobe_pipe_q[`OSC_CYCLES-3:0], bdout_o};
            output_strobe_stage2_q <= strobe_pipe_q[`OSC_CYCLES-2];
        end
    end

    // end of phase five: load chip set; end of phase-bar: parity check
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            chip_set_data_o <= 16'h0000;
            chip_set_load_o <= 1'b0;
            captured_parity_bits_q <= 2'h0;
            address_parity_error_q <= 1'b0;
            chip_reset_o <= 1'b0;
            trap_vector_o <= 16'h0000;
        end else begin
            chip_set_load_o <= 1'b0;
            if (backplane_read_enable_q)
                captured_parity_bits_q <= bdal_i[17:16];
            if (state_q == ST_PT5 && tick_q >= OSC_N && ~is_write_q) begin
                chip_set_data_o <= processor_bus_o[15:0];
                chip_set_load_o <= 1'b1;
            end
            if (state_q == ST_PBT && one_osc) begin
                address_parity_error_q <= &captured_parity_bits_q;
                chip_reset_o <= &captured_parity_bits_q;
                if (&captured_parity_bits_q)
                    trap_vector_o <= `PAR_TRAP_VEC;
                captured_parity_bits_q <= 2'h0;
            end else
                chip_reset_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== sim/bp_slave_model.sv ====
// backplane slave: replies to data-in and data-out strobes after a set wait
// assumes the bench merges its lines with the controller's drive
`timescale 1ns/100ps
`default_nettype none
module bp_slave_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        bdin_i,
    input  wire logic        bdout_i,
    input  wire logic [2:0]  dly_i,
    input  wire logic [18:0] rdata_i,
    output var  logic        brply_o,
    output var  logic [18:0] bdal_o
);
    logic [2:0] cnt_q;
    // lines toggle when idle so stale data never looks valid
    always @(posedge clk_i) begin
        if (rst_i) begin
            brply_o <= 1'b0;
            cnt_q <= 3'h0;
            bdal_o <= 19'h00000;
        end else if (bdin_i || bdout_i) begin
            if (cnt_q == dly_i) begin
                brply_o <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 3'h1;
            end
            bdal_o <= (bdin_i && cnt_q == dly_i) ? rdata_i : ~bdal_o;
        end else begin
            brply_o <= 1'b0;
            cnt_q <= 3'h0;
            bdal_o <= ~bdal_o;
        end
    end
endmodule
`default_nettype wire

// ==== sim/bus_cycle_ctrl_checker.sv ====
// timing checks on the bus cycle controller ports
// assumes one clock domain and a bind onto every controller instance
`timescale 1ns/100ps
`default_nettype none
module bus_cycle_ctrl_checker (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        bdal_oe_o,
    input wire logic        bsync_o,
    input wire logic        bdin_o,
    input wire logic        bdout_o,
    input wire logic        biako_o,
    input wire logic        bwtbt_o,
    input wire logic        brply_i,
    input wire logic        interrupt_ack_microbit_o,
    input wire logic        chip_set_load_o,
    input wire logic        chip_reset_o,
    input wire logic [15:0] trap_vector_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_wb_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_sync_iak; $rose(bsync_o) |-> !interrupt_ack_microbit_o; endproperty
    property p_rd_gate; $rose(bdin_o) |-> ##[1:16] !bdal_oe_o; endproperty
    property p_iak_bit; biako_o |-> interrupt_ack_microbit_o; endproperty
    property p_ack_gate; biako_o |-> !bdal_oe_o; endproperty
    property p_wtbt_rd; bdin_o |-> !bwtbt_o; endproperty
    property p_out_stage; $fell(bdout_o) |-> bdal_oe_o; endproperty
    property p_dout_wr; bdout_o |-> !bdin_o && !interrupt_ack_microbit_o; endproperty
    property p_sync_hold; bsync_o && brply_i |=> bsync_o; endproperty
    property p_trap; chip_reset_o |=> !chip_reset_o && trap_vector_o == 16'h004C; endproperty
    property p_load; chip_set_load_o |-> !bdout_o; endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("bus ack missing");
    a_sync_iak: assert property (p_sync_iak) else $error("sync on ack read");
    a_rd_gate: assert property (p_rd_gate) else $error("address kept on read");
    a_iak_bit: assert property (p_iak_bit) else $error("ack out on plain read");
    a_ack_gate: assert property (p_ack_gate) else $error("ack out with gate on");
    a_wtbt_rd: assert property (p_wtbt_rd) else $error("byte flag on read");
    a_out_stage: assert property (p_out_stage) else $error("drive dropped early");
    a_dout_wr: assert property (p_dout_wr) else $error("out strobe on read");
    a_sync_hold: assert property (p_sync_hold) else $error("sync dropped early");
    a_trap: assert property (p_trap) else $error("bad parity trap");
    a_load: assert property (p_load) else $error("load during write");
    c_write: cover property ($rose(bdout_o));
    c_read: cover property ($rose(bdin_o));
    c_ext_iak: cover property ($rose(biako_o));
    c_reset: cover property (chip_reset_o);
endmodule
bind bus_cycle_ctrl bus_cycle_ctrl_checker chk_u (.ref_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .bdal_oe_o, .bsync_o, .bdin_o, .bdout_o, .biako_o, .bwtbt_o, .brply_i,
    .interrupt_ack_microbit_o, .chip_set_load_o, .chip_reset_o, .trap_vector_o);
`default_nettype wire

// ==== sim/backplane_bus_cycle_control_tb.sv ====
// bench: runs every cycle kind through the controller against a slave model
// assumes the register map and control bits of the shared header
`timescale 1ns/100ps
`default_nettype none
`include "bus_cycle_regs.vh"
module backplane_bus_cycle_control_tb;
    logic ref_clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, bdal_oe_o;
    logic bsync_o, bdin_o, bdout_o, biako_o, bbs7_o, bwtbt_o, birq5_i, birq6_i;
    logic serial_unit_int_request_i, mapper_reply_i, internal_address_select_i;
    logic console_addr_bit17_i, console_addr_bit16_i, internal_write_strobe_o;
    logic interrupt_ack_microbit_o, chip_set_load_o, chip_reset_o, brply_i;
    logic [3:0]  wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, st;
    logic [18:0] bdal_i, bdal_o, processor_bus_o, sl_bdal, sl_data, bd_cap;
    logic [15:0] onboard_register_bus_i, onboard_register_bus_o, chip_set_data_o;
    logic [15:0] trap_vector_o, cs_q, exp_d;
    logic [1:0]  microbits_7_6_i;
    logic [2:0]  sl_dly;
    logic [6:0]  ctl [10] = '{7'h41, 7'h01, 7'h05, 7'h0D, 7'h15, 7'h03, 7'h03,
                              7'h61, 7'h01, 7'h01};
    logic        bw_cap, dout_q;
    int num_errors = 0, checks_done = 0, seed = 60894, k, kd, ld0, ik0, bs0, rs0;
    int n_load = 0, n_iak = 0, n_bbs7 = 0, n_rst = 0;
    logic [31:0] rd;
    bus_cycle_ctrl dut_u (.ref_clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bdal_i, .bdal_o, .bdal_oe_o, .bsync_o,
        .bdin_o, .bdout_o, .biako_o, .bbs7_o, .bwtbt_o, .brply_i, .birq5_i, .birq6_i,
        .serial_unit_int_request_i, .mapper_reply_i, .internal_address_select_i,
        .console_addr_bit17_i, .console_addr_bit16_i, .microbits_7_6_i,
        .onboard_register_bus_i, .onboard_register_bus_o, .internal_write_strobe_o,
        .interrupt_ack_microbit_o, .processor_bus_o, .chip_set_data_o, .chip_set_load_o,
        .chip_reset_o, .trap_vector_o);
    bp_slave_model slave_u (.clk_i(ref_clk_i), .rst_i(rst_i), .bdin_i(bdin_o),
        .bdout_i(bdout_o), .dly_i(sl_dly), .rdata_i(sl_data), .brply_o(brply_i),
        .bdal_o(sl_bdal));
    // merged backplane lines: controller drive wins while enabled
    assign bdal_i = (bdal_oe_o === 1'b1) ? bdal_o : sl_bdal;
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    // monitor: latch what each cycle showed on the backplane and chip set side
    always @(posedge ref_clk_i) begin
        dout_q <= bdout_o;
        if (chip_set_load_o === 1'b1) begin
            cs_q <= chip_set_data_o;
            n_load <= n_load + 1;
        end
        if (bdout_o === 1'b1 && dout_q !== 1'b1) begin
            bd_cap <= bdal_o;
            bw_cap <= bwtbt_o;
        end
        if (biako_o === 1'b1) n_iak <= n_iak + 1;
        if (bsync_o === 1'b1 && bbs7_o === 1'b1) n_bbs7 <= n_bbs7 + 1;
        if (chip_reset_o === 1'b1) n_rst <= n_rst + 1;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // classic single cycle; request held until ack is seen at an edge
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) cmp("wb ack", 1, 0);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // start one bus cycle and poll busy, bounded
    task automatic run(input logic [6:0] c, input logic [15:0] w);
        int n;
        wb(1'b1, `REG_WDATA, {16'h0000, w}, st);
        wb(1'b1, `REG_CTRL, {25'h0, c}, st);
        n = 0;
        st = 32'h00000001;
        while (st[0] !== 1'b0 && n < 100) begin
            wb(1'b0, `REG_STATUS, 32'h0, st);
            n++;
        end
        if (n >= 100) cmp("busy", 0, 1);
    endtask
    initial begin
        #(20 * 20000);
        num_errors++;
        results();
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, birq5_i, birq6_i} = 5'h00;
        {serial_unit_int_request_i, mapper_reply_i, internal_address_select_i} = 3'h0;
        {console_addr_bit17_i, console_addr_bit16_i} = 2'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i, microbits_7_6_i} = {4'h0, 4'hF, 32'h0, 2'h0};
        {onboard_register_bus_i, sl_data, sl_dly} = {16'h0000, 19'h00000, 3'h0};
        rst_i = 1'b1;
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        for (k = 0; k < 20; k++) begin
            kd = k % 10;
            rd = $random(seed);
            sl_data <= {rd[18], (kd == 8) ? 2'b11 : 2'b00, rd[15:0]};
            sl_dly <= rd[22:20];
            onboard_register_bus_i <= rd[31:16];
            internal_address_select_i <= (kd == 1);
            mapper_reply_i <= (kd == 2);
            {console_addr_bit17_i, console_addr_bit16_i} <= rd[26:25];
            serial_unit_int_request_i <= (kd == 5 || kd == 6);
            birq5_i <= (kd == 6);
            birq6_i <= rd[23] && kd != 5;
            microbits_7_6_i <= (kd == 7) ? 2'h1 : {rd[24], 1'b0};
            {ld0, ik0, bs0, rs0} = {n_load, n_iak, n_bbs7, n_rst};
            wb(1'b1, `REG_ADDR, {13'h0, rd[18:0]}, st);
            run(ctl[kd], rd[31:16]);
            exp_d = (kd == 1 || kd == 5) ? rd[31:16] : rd[15:0];
            if (kd >= 2 && kd <= 4) begin
                cmp("onboard data", rd[31:16], onboard_register_bus_o);
                cmp("bdal data", rd[31:16], bd_cap[15:0]);
                cmp("byte flag", kd == 3, bw_cap);
                cmp("loads", ld0, n_load);
            end else begin
                cmp("chip data", exp_d, cs_q);
                cmp("status data", exp_d, st[18:3]);
                cmp("loads", ld0 + 1, n_load);
            end
            cmp("local ack", kd == 5, st[2]);
            cmp("ack out", kd == 6, n_iak > ik0);
            if (kd == 0 || kd == 7)
                cmp("io page", kd == 0 || &rd[26:25], n_bbs7 > bs0);
            cmp("chip reset", kd == 9, n_rst > rs0);
            if (kd == 9) cmp("trap", 16'h004C, trap_vector_o);
        end
        results();
    end
endmodule
`default_nettype wire
